// file: common/spp_defs.svh
// constants for the serially programmed pulse generator
`ifndef SPP_DEFS_SVH
`define SPP_DEFS_SVH

`define SPP_REG_W        8
`define SPP_SHIFT_W      24
`define SPP_BITCNT_W     5
`define SPP_BITCNT_MAX   5'h1F
`define SPP_BITS_ONE     5'h08
`define SPP_BITS_TWO     5'h10
`define SPP_BITS_THREE   5'h18
`define SPP_CD_BIT       0
`define SPP_PC_BIT       1
`define SPP_CTRL_RST     8'h00
`define SPP_FREQ_RST     8'h00
`define SPP_PW_RST       8'h00
`define SPP_PIN_W        5
`define SPP_PIN_SRC      0
`define SPP_PIN_CS       1
`define SPP_PIN_SCK      2
`define SPP_PIN_DATA     3
`define SPP_PIN_VT       4
`define SPP_PIN_RST      5'h02

`endif

// file: common/spp_pkg.sv
// types for the serially programmed pulse generator
package spp_pkg;

  typedef enum logic [1:0] {
    LOAD_NONE,
    LOAD_PW,
    LOAD_FREQ_PW,
    LOAD_ALL
  } spp_load_t;

  typedef enum logic {
    GEN_IDLE,
    GEN_RUN
  } spp_gen_t;

endpackage

// file: logic/spp_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module spp_pin_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // pins
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  // ----------------------------------------
  // per-bit chain
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          stage1_r[i] <= RST_VAL[i];
          stage2_r[i] <= RST_VAL[i];
          stage3_r[i] <= RST_VAL[i];
          pinOut[i]   <= RST_VAL[i];
        end else begin
          stage1_r[i] <= pinIn[i];
          stage2_r[i] <= stage1_r[i];
          stage3_r[i] <= stage2_r[i];
          if (stage2_r[i] == stage3_r[i]) begin
            pinOut[i] <= stage3_r[i];
          end
        end
      end
    end
  endgenerate

endmodule

// file: logic/spp_top.sv
// serially programmed pulse generator core
`timescale 1ns/1ps
`include "spp_defs.svh"
module spp_top (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // device pins
  input  wire logic                   srcClk,
  input  wire logic                   chipSelN,
  input  wire logic                   serialClk,
  input  wire logic                   serialData,
  input  wire logic                   thresholdShutdownInput,
  output logic                        pwmOut,
  // status
  output logic [`SPP_REG_W-1:0]       ctrlReg,
  output logic [`SPP_REG_W-1:0]       freqReg,
  output logic [`SPP_REG_W-1:0]       pwReg,
  output logic                        shutdownActive,
  output logic                        configured,
  output logic                        running
);

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  logic [`SPP_PIN_W-1:0] pinRaw;
  logic [`SPP_PIN_W-1:0] pinFilt;
  logic [`SPP_PIN_W-1:0] pinPrev_r;

  assign pinRaw[`SPP_PIN_SRC]  = srcClk;
  assign pinRaw[`SPP_PIN_CS]   = chipSelN;
  assign pinRaw[`SPP_PIN_SCK]  = serialClk;
  assign pinRaw[`SPP_PIN_DATA] = serialData;
  assign pinRaw[`SPP_PIN_VT]   = thresholdShutdownInput;

  spp_pin_sync #(
    .WIDTH   (`SPP_PIN_W),
    .RST_VAL (`SPP_PIN_RST)
  ) u_spp_pin_sync (
    .clock  (clock),
    .rst    (rst),
    .pinIn  (pinRaw),
    .pinOut (pinFilt)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pinPrev_r <= `SPP_PIN_RST;
    end else begin
      pinPrev_r <= pinFilt;
    end
  end

  logic srcFall;
  logic csFall;
  logic csRise;
  logic sckRise;
  logic selected;
  logic vtHigh;

  assign srcFall  = pinPrev_r[`SPP_PIN_SRC] & ~pinFilt[`SPP_PIN_SRC];
  assign csFall   = pinPrev_r[`SPP_PIN_CS] & ~pinFilt[`SPP_PIN_CS];
  assign csRise   = ~pinPrev_r[`SPP_PIN_CS] & pinFilt[`SPP_PIN_CS];
  assign sckRise  = ~pinPrev_r[`SPP_PIN_SCK] & pinFilt[`SPP_PIN_SCK];
  assign selected = ~pinFilt[`SPP_PIN_CS];
  assign vtHigh   = pinFilt[`SPP_PIN_VT];

  // ----------------------------------------
  // serial shift register and bit count
  // ----------------------------------------
  logic [`SPP_SHIFT_W-1:0]  shift_r;
  logic [`SPP_BITCNT_W-1:0] bitCnt_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_r  <= '0;
      bitCnt_r <= '0;
    end else if (csFall || csRise) begin
      bitCnt_r <= '0;
    end else if (selected && sckRise) begin
      shift_r <= {shift_r[`SPP_SHIFT_W-2:0], pinFilt[`SPP_PIN_DATA]};
      if (bitCnt_r != `SPP_BITCNT_MAX) begin
        bitCnt_r <= bitCnt_r + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // latch decode
  // ----------------------------------------
  spp_pkg::spp_load_t loadKind;
  logic [`SPP_REG_W-1:0] newCtrl;
  logic [`SPP_REG_W-1:0] newFreq;
  logic [`SPP_REG_W-1:0] newPw;
  logic                  latchEv;
  logic                  configured_nxt;

  always_comb begin
    loadKind = spp_pkg::LOAD_NONE;
    if (csRise) begin
      if (bitCnt_r == `SPP_BITS_THREE) begin
        loadKind = spp_pkg::LOAD_ALL;
      end else if (bitCnt_r == `SPP_BITS_TWO) begin
        loadKind = spp_pkg::LOAD_FREQ_PW;
      end else if (bitCnt_r == `SPP_BITS_ONE) begin
        loadKind = spp_pkg::LOAD_PW;
      end
    end
  end

  always_comb begin
    newCtrl = ctrlReg;
    newFreq = freqReg;
    newPw   = pwReg;
    unique case (loadKind)
      spp_pkg::LOAD_NONE: begin
      end
      spp_pkg::LOAD_PW: begin
        newPw = shift_r[7:0];
      end
      spp_pkg::LOAD_FREQ_PW: begin
        newFreq = shift_r[15:8];
        newPw   = shift_r[7:0];
      end
      spp_pkg::LOAD_ALL: begin
        newCtrl = shift_r[23:16];
        newFreq = shift_r[15:8];
        newPw   = shift_r[7:0];
      end
    endcase
  end

  assign latchEv        = (loadKind != spp_pkg::LOAD_NONE);
  assign configured_nxt = configured | (loadKind == spp_pkg::LOAD_ALL);

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrlReg    <= `SPP_CTRL_RST;
      freqReg    <= `SPP_FREQ_RST;
      pwReg      <= `SPP_PW_RST;
      configured <= 1'b0;
    end else if (latchEv) begin
      ctrlReg    <= newCtrl;
      freqReg    <= newFreq;
      pwReg      <= newPw;
      configured <= configured_nxt;
    end
  end

  // ----------------------------------------
  // threshold shutdown
  // ----------------------------------------
  logic selAfterLow_r;
  logic shutRelease;

  assign shutRelease = latchEv & selAfterLow_r & ~vtHigh;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      selAfterLow_r <= 1'b0;
    end else if (vtHigh) begin
      selAfterLow_r <= 1'b0;
    end else if (csFall) begin
      selAfterLow_r <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shutdownActive <= 1'b0;
    end else if (vtHigh && !newCtrl[`SPP_PC_BIT]) begin
      shutdownActive <= 1'b1;
    end else if (shutRelease) begin
      shutdownActive <= 1'b0;
    end
  end

  // ----------------------------------------
  // generator state
  // ----------------------------------------
  spp_pkg::spp_gen_t genState_r;
  logic startOk;
  logic stopNow;

  assign startOk = latchEv & configured_nxt & ~newCtrl[`SPP_PC_BIT]
                 & ~vtHigh & (~shutdownActive | shutRelease);
  assign stopNow = (vtHigh & ~ctrlReg[`SPP_PC_BIT])
                 | (latchEv & newCtrl[`SPP_PC_BIT]);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      genState_r <= spp_pkg::GEN_IDLE;
    end else begin
      unique case (genState_r)
        spp_pkg::GEN_IDLE: begin
          if (startOk) begin
            genState_r <= spp_pkg::GEN_RUN;
          end
        end
        spp_pkg::GEN_RUN: begin
          if (stopNow) begin
            genState_r <= spp_pkg::GEN_IDLE;
          end
        end
      endcase
    end
  end

  logic restart;
  assign restart = (genState_r == spp_pkg::GEN_IDLE) & startOk;

  // ----------------------------------------
  // pulse generator core
  // ----------------------------------------
  logic                  actCd_r;
  logic [`SPP_REG_W-1:0] actFreq_r;
  logic [`SPP_REG_W-1:0] actPw_r;
  logic [`SPP_REG_W-1:0] cnt_r;
  logic                  divPhase_r;
  logic                  pending_r;
  logic                  tick;
  logic                  periodEnd;
  logic                  isRun;

  assign isRun     = (genState_r == spp_pkg::GEN_RUN);
  assign tick      = isRun & srcFall & (~actCd_r | divPhase_r);
  assign periodEnd = tick & (cnt_r == actFreq_r);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divPhase_r <= 1'b0;
    end else if (restart) begin
      divPhase_r <= 1'b0;
    end else if (isRun && srcFall) begin
      divPhase_r <= ~divPhase_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (restart || periodEnd) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pending_r <= 1'b0;
    end else if (latchEv) begin
      pending_r <= 1'b1;
    end else if (periodEnd || restart) begin
      pending_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      actCd_r   <= 1'b0;
      actFreq_r <= `SPP_FREQ_RST;
      actPw_r   <= `SPP_PW_RST;
    end else if (restart) begin
      actCd_r   <= newCtrl[`SPP_CD_BIT];
      actFreq_r <= newFreq;
      actPw_r   <= newPw;
    end else if (periodEnd && pending_r) begin
      actCd_r   <= ctrlReg[`SPP_CD_BIT];
      actFreq_r <= freqReg;
      actPw_r   <= pwReg;
    end
  end

  // ----------------------------------------
  // output
  // ----------------------------------------
  logic                  pwmOut_nxt;
  logic [`SPP_REG_W-1:0] cntNow;
  logic [`SPP_REG_W-1:0] pwNow;

  always_comb begin
    cntNow = cnt_r;
    pwNow  = actPw_r;
    if (restart) begin
      cntNow = '0;
      pwNow  = newPw;
    end else if (periodEnd) begin
      cntNow = '0;
      if (pending_r) begin
        pwNow = pwReg;
      end
    end else if (tick) begin
      cntNow = cnt_r + 8'h01;
    end
    pwmOut_nxt = (isRun | restart) & ~stopNow & ~vtHigh
               & (cntNow <= pwNow);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwmOut  <= 1'b0;
      running <= 1'b0;
    end else begin
      pwmOut  <= pwmOut_nxt;
      running <= (isRun & ~stopNow) | restart;
    end
  end

endmodule

// file: verif/spp_checker.sv
// concurrent checks on the pulse generator ports
`timescale 1ns/1ps
`include "spp_defs.svh"
module spp_checker (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 rst,
  // pins
  input wire logic                 chipSelN,
  input wire logic                 thresholdShutdownInput,
  input wire logic                 pwmOut,
  // status
  input wire logic [`SPP_REG_W-1:0] ctrlReg,
  input wire logic [`SPP_REG_W-1:0] freqReg,
  input wire logic [`SPP_REG_W-1:0] pwReg,
  input wire logic                 shutdownActive,
  input wire logic                 configured,
  input wire logic                 running
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_shut_low: assert property (shutdownActive [*2] |-> !pwmOut)
    else $error("output high during shutdown");
  chk_thr_shut: assert property (
    (!ctrlReg[1] && thresholdShutdownInput) [*8]
    |-> shutdownActive && !pwmOut)
    else $error("threshold did not force output low");
  chk_shut_stay: assert property (
    shutdownActive && !chipSelN |=> shutdownActive)
    else $error("shutdown released without latch");
  chk_sel_hold: assert property (!chipSelN [*8] |->
    $stable(pwReg) && $stable(freqReg) && $stable(ctrlReg))
    else $error("registers changed while selected");
  chk_idle_hold: assert property (chipSelN [*8] ##1 chipSelN |->
    $stable(pwReg) && $stable(freqReg) && $stable(ctrlReg))
    else $error("registers changed without transfer");
  chk_start_high: assert property ($rose(running) |-> ##[0:1] pwmOut)
    else $error("output not high at start");
  chk_pc_low: assert property (ctrlReg[1] [*2] |-> !pwmOut && !running)
    else $error("output active while powered down");
  chk_cfg_hold: assert property (configured |=> configured)
    else $error("configured flag dropped");
  chk_cfg_run: assert property (running |-> configured)
    else $error("running before full write");

  cover property ($rose(running));
  cover property ($rose(shutdownActive));
  cover property ($fell(shutdownActive));
endmodule

bind spp_top spp_checker u_spp_checker (
  .clock(clock), .rst(rst), .chipSelN(chipSelN),
  .thresholdShutdownInput(thresholdShutdownInput), .pwmOut(pwmOut),
  .ctrlReg(ctrlReg), .freqReg(freqReg), .pwReg(pwReg),
  .shutdownActive(shutdownActive), .configured(configured),
  .running(running)
);

// file: verif/spp_serial_master.sv
// serial master model that writes the pulse generator
`timescale 1ns/1ps
module spp_serial_master (
  // clock
  input wire logic clock,
  // serial link
  output logic     chipSelN,
  output logic     serialClk,
  output logic     serialData
);
  initial begin
    chipSelN = 1'b1;
    serialClk = 1'b0;
    serialData = 1'b0;
  end

  task automatic hold();
    repeat (5) @(negedge clock);
  endtask

  // n low bits of val, most significant first
  task automatic send(input logic [23:0] val, input int n);
    chipSelN = 1'b0;
    hold();
    for (int i = n - 1; i >= 0; i--) begin
      serialData = val[i];
      hold();
      serialClk = 1'b1;
      hold();
      serialClk = 1'b0;
    end
    hold();
    chipSelN = 1'b1;
    serialData = ~serialData;
    repeat (12) @(negedge clock);
  endtask
endmodule

// file: verif/test_spp_top.sv
// self-checking bench for the pulse generator
`timescale 1ns/1ps
module test_spp_top;
  logic       clock, rst, srcClk, thrIn, chipSelN, serialClk, serialData;
  logic       pwmOut, shutdownActive, configured, running;
  logic [7:0] ctrlReg, freqReg, pwReg;
  int         fail_count = 0;
  int         check_count = 0;
  int         hi, per, cnt;
  typedef struct {
    int n; logic [23:0] v; logic [7:0] c, f, p; logic r;
  } spp_row_t;
  spp_row_t   rows [6] = '{
    '{8, 24'h000003, 8'h00, 8'h00, 8'h03, 1'b0},
    '{24, 24'h000503, 8'h00, 8'h05, 8'h03, 1'b1},
    '{16, 24'h000401, 8'h00, 8'h04, 8'h01, 1'b1},
    '{8, 24'h000002, 8'h00, 8'h04, 8'h02, 1'b1},
    '{12, 24'h000FFF, 8'h00, 8'h04, 8'h02, 1'b1},
    '{24, 24'h010300, 8'h01, 8'h03, 8'h00, 1'b1}};

  spp_top u_spp_top (.clock(clock), .rst(rst), .srcClk(srcClk),
    .chipSelN(chipSelN), .serialClk(serialClk), .serialData(serialData),
    .thresholdShutdownInput(thrIn), .pwmOut(pwmOut), .ctrlReg(ctrlReg),
    .freqReg(freqReg), .pwReg(pwReg), .shutdownActive(shutdownActive),
    .configured(configured), .running(running));
  spp_serial_master u_spp_serial_master (.clock(clock),
    .chipSelN(chipSelN), .serialClk(serialClk), .serialData(serialData));

  // ------------------------------------------------------------
  // clocks
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    srcClk = 1'b0;
    forever begin
      repeat (5) @(negedge clock);
      srcClk = ~srcClk;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wait_lvl(input logic v);
    for (int t = 0; t < 2000 && pwmOut !== v; t++) @(negedge clock);
  endtask
  task automatic measure();
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    for (hi = 0; hi < 2000 && pwmOut === 1'b1; hi++) @(negedge clock);
    for (per = hi; per < 4000 && pwmOut === 1'b0; per++) @(negedge clock);
  endtask
  task automatic count_high(input int n);
    cnt = 0;
    repeat (n) begin
      @(negedge clock);
      if (pwmOut !== 1'b0) cnt++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #100us;
    fail_count++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    thrIn = 1'b0;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (6) @(negedge clock);
    check("pwm", pwmOut, 16'h0000);
    foreach (rows[i]) begin
      u_spp_serial_master.send(rows[i].v, rows[i].n);
      check("ctrl", ctrlReg, rows[i].c);
      check("freq", freqReg, rows[i].f);
      check("pw", pwReg, rows[i].p);
      check("run", running, rows[i].r);
      if (rows[i].r) begin
        measure();
        check("high", hi, 16'((rows[i].p + 1) * (rows[i].c[0] + 1) * 10));
        check("period", per, 16'((rows[i].f + 1) * (rows[i].c[0] + 1) * 10));
      end
    end
    check("cfg", configured, 16'h0001);
    thrIn = 1'b1;
    repeat (10) @(negedge clock);
    check("shut", shutdownActive, 16'h0001);
    check("out", pwmOut, 16'h0000);
    u_spp_serial_master.send(24'h000001, 8);
    check("shut_hi", shutdownActive, 16'h0001);
    thrIn = 1'b0;
    count_high(200);
    check("held", cnt, 16'h0000);
    u_spp_serial_master.send(24'h000001, 8);
    check("release", shutdownActive, 16'h0000);
    measure();
    check("rel_high", hi, 16'h0028);
    u_spp_serial_master.send(24'h020401, 24);
    count_high(200);
    check("off_out", cnt, 16'h0000);
    check("off_run", running, 16'h0000);
    u_spp_serial_master.send(24'h000401, 24);
    check("on_run", running, 16'h0001);
    rst = 1'b1;
    @(negedge clock);
    check("rst_pw", pwReg, 16'h0000);
    check("rst_cfg", configured, 16'h0000);
    check("rst_out", pwmOut, 16'h0000);
    rst = 1'b0;
    give_verdict();
  end
endmodule
